// >>> src/psv_pkg.sv
// Package of constants and types for the program space data window bridge.
package psv_pkg;
	localparam logic [31:0] ADDR_CORE_CONTROL = 32'h0000_0000;
	localparam logic [31:0] ADDR_VIEW_PAGE    = 32'h0000_0004;
	localparam logic [31:0] ADDR_TABLE_PAGE   = 32'h0000_0008;
	localparam logic [31:0] ADDR_PROG_HI      = 32'h0000_000C;
	localparam logic [31:0] ADDR_PROG_LO      = 32'h0000_0010;
	localparam logic [31:0] ADDR_EE_CMD       = 32'h0000_0014;
	localparam logic [31:0] ADDR_STATUS       = 32'h0000_0018;
	localparam int          CORE_VIEW_EN_BIT  = 2;
	localparam int          DATA_TOP_BIT      = 15;
	localparam int          PAGE_HI_BIT       = 7;
	localparam logic [7:0]  PAGE_PROGRAM      = 8'h00;
	localparam logic [7:0]  PAGE_EEPROM       = 8'hFF;
	localparam logic [7:0]  PAGE_RESET        = 8'h00;
	localparam logic [15:0] CORE_RESET        = 16'h0000;
	localparam logic [1:0]  AXI_OKAY          = 2'h0;
	localparam logic [1:0]  AXI_SLVERR        = 2'h2;
	localparam logic [1:0]  EXTRA_ONE         = 2'h1;
	localparam logic [1:0]  EXTRA_TWO         = 2'h2;
	localparam logic [1:0]  EXTRA_NONE        = 2'h0;
	localparam int          EE_BUSY_CYCLES    = 16;
	typedef enum logic [2:0] {
		EE_NONE   = 3'h0,
		EE_ERASE1 = 3'h1,
		EE_ERASE4 = 3'h2,
		EE_ERASE8 = 3'h3,
		EE_BULK   = 3'h4,
		EE_WRITE  = 3'h5,
		EE_READ   = 3'h6
	} ee_op_t;
endpackage : psv_pkg

// >>> src/psv_if.sv
// Interface between the window front end and the address former.
`timescale 1ns/10ps
`default_nettype none
interface psv_if;
	logic        view_en;
	logic [7:0]  view_page;
	logic [7:0]  table_page;
	logic        table_busy;
	logic [15:0] data_addr;
	logic        window_hit;
	logic [23:0] window_addr;
	modport former (input view_en, view_page, table_page, table_busy, data_addr, output window_hit, window_addr);
	modport user   (output view_en, view_page, table_page, table_busy, data_addr, input window_hit, window_addr);
endinterface : psv_if
`default_nettype wire

// >>> src/psv_addr_former.sv
// Combinational program space address former for the view window.
`timescale 1ns/10ps
`default_nettype none
module psv_addr_former (
	// Window link.
	psv_if.former link
);
	// Hit requires top address bit, enable, and no table operation.
	assign link.window_hit = link.data_addr[psv_pkg::DATA_TOP_BIT] & link.view_en
		& ~link.table_busy;
	// Page forms bits 22..15 above a zero bit 23; data bit 15 is replaced by page bit 0.
	assign link.window_addr = {1'b0, link.view_page[7:1], link.view_page[0],
		link.data_addr[14:0]};
endmodule : psv_addr_former
`default_nettype wire

// >>> src/program_space_data_window.sv
// Top of the program space data window bridge with AXI4-Lite registers.
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module program_space_data_window (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address.
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	// AXI4-Lite write data.
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	// AXI4-Lite write response.
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address.
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	// AXI4-Lite read data.
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Core data access request.
	input  wire logic        core_req,
	input  wire logic [15:0] core_addr,
	input  wire logic        core_move_op,
	input  wire logic        core_in_repeat,
	input  wire logic        core_rep_edge,
	// Core table operation request.
	input  wire logic        tbl_req,
	input  wire logic        tbl_write,
	input  wire logic        tbl_high,
	input  wire logic [15:0] tbl_addr,
	input  wire logic [15:0] tbl_wdata,
	// Program memory port.
	input  wire logic [23:0] prog_rdata,
	// Answers to the core.
	output logic             core_redirect,
	output logic [1:0]       core_extra_cycles,
	output logic [15:0]      core_rdata,
	output logic [23:0]      prog_addr,
	output logic             tbl_ignored,
	output logic             ee_busy,
	output logic [15:0]      ee_wdata
);
	logic [15:0] core_control_reg;
	logic [7:0]  view_page_reg;
	logic [7:0]  table_page_reg;
	logic [7:0]  prog_hi_reg;
	logic [15:0] prog_lo_reg;
	logic [2:0]  ee_op_reg;
	logic [4:0]  ee_count_reg;
	logic        tbl_busy_reg;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [31:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic        wr_go;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_word;
	logic        ee_start;
	logic        page_ok;
	psv_if       link ();

	// Window address former instance.
	psv_addr_former former_i (
		.link (link.former)
	);
	assign link.view_en    = core_control_reg[psv_pkg::CORE_VIEW_EN_BIT];
	assign link.view_page  = view_page_reg;
	assign link.table_page = table_page_reg;
	assign link.table_busy = tbl_busy_reg | tbl_req;
	assign link.data_addr  = core_addr;

	// Write channel capture; address and data may arrive in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= 32'h0000_0000;
			w_data_reg  <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
			end else if (wr_go) begin
				w_held_reg <= 1'b0;
			end
		end
	end
	assign wr_go = aw_held_reg & w_held_reg & ~s_axi_bvalid;

	// Ready flags and write response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= psv_pkg::AXI_OKAY;
		end else begin
			s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
			s_axi_wready  <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? psv_pkg::AXI_OKAY : psv_pkg::AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Write address decode; all seven register addresses hit, the read-only ones too.
	always_comb begin
		wr_hit = 1'b1;
		unique case (aw_addr_reg)
			psv_pkg::ADDR_CORE_CONTROL, psv_pkg::ADDR_VIEW_PAGE, psv_pkg::ADDR_TABLE_PAGE,
			psv_pkg::ADDR_EE_CMD, psv_pkg::ADDR_PROG_HI, psv_pkg::ADDR_PROG_LO,
			psv_pkg::ADDR_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end
	assign page_ok = (w_data_reg[7:0] == psv_pkg::PAGE_PROGRAM) || (w_data_reg[7:0] == psv_pkg::PAGE_EEPROM);

	// Control and page registers; illegal view page values are dropped.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_control_reg <= psv_pkg::CORE_RESET;
			view_page_reg    <= psv_pkg::PAGE_RESET;
			table_page_reg   <= psv_pkg::PAGE_RESET;
		end else if (wr_go) begin
			if (aw_addr_reg == psv_pkg::ADDR_CORE_CONTROL && s_axi_wstrb[0])
				core_control_reg[7:0] <= w_data_reg[7:0];
			if (aw_addr_reg == psv_pkg::ADDR_CORE_CONTROL && s_axi_wstrb[1])
				core_control_reg[15:8] <= w_data_reg[15:8];
			if (aw_addr_reg == psv_pkg::ADDR_VIEW_PAGE && s_axi_wstrb[0] && page_ok)
				view_page_reg <= w_data_reg[7:0];
			if (aw_addr_reg == psv_pkg::ADDR_TABLE_PAGE && s_axi_wstrb[0])
				table_page_reg <= w_data_reg[7:0];
		end
	end

	// Table operation: capture programming address on low-word writes, flag high-word ops on the EEPROM page as ignored.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_hi_reg  <= 8'h00;
			prog_lo_reg  <= 16'h0000;
			tbl_busy_reg <= 1'b0;
			tbl_ignored  <= 1'b0;
			ee_wdata     <= 16'h0000;
		end else begin
			tbl_busy_reg <= tbl_req;
			tbl_ignored  <= tbl_req & tbl_high & (table_page_reg == psv_pkg::PAGE_EEPROM);
			if (tbl_req && tbl_write && !tbl_high) begin
				prog_hi_reg <= {1'b0, table_page_reg[6:0]};
				prog_lo_reg <= {tbl_addr[15:1], 1'b0};
				ee_wdata    <= tbl_wdata;
			end
		end
	end

	// EEPROM operation sequencer with busy count.
	assign ee_start = wr_go && aw_addr_reg == psv_pkg::ADDR_EE_CMD && s_axi_wstrb[0] && ee_count_reg == 5'h00
		&& w_data_reg[2:0] != psv_pkg::EE_NONE && w_data_reg[2:0] <= psv_pkg::EE_READ;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ee_op_reg    <= psv_pkg::EE_NONE;
			ee_count_reg <= 5'h00;
			ee_busy      <= 1'b0;
		end else begin
			if (ee_start) begin
				ee_op_reg    <= w_data_reg[2:0];
				ee_count_reg <= 5'(psv_pkg::EE_BUSY_CYCLES);
				ee_busy      <= 1'b1;
			end else if (ee_count_reg != 5'h00) begin
				ee_count_reg <= ee_count_reg - 5'h01;
				ee_busy      <= ee_count_reg != 5'h01;
			end
		end
	end

	// Core window access: address, data and stall cycles.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_redirect     <= 1'b0;
			core_extra_cycles <= psv_pkg::EXTRA_NONE;
			core_rdata        <= 16'h0000;
			prog_addr         <= 24'h00_0000;
		end else begin
			core_redirect <= core_req & link.window_hit;
			if (tbl_req)
				prog_addr <= {table_page_reg, tbl_addr};
			else if (core_req && link.window_hit)
				prog_addr <= link.window_addr;
			else
				prog_addr <= {1'b0, 7'h00, core_addr[15:1], 1'b0};
			core_rdata <= prog_addr[0] ? {8'h00, prog_rdata[23:16]} : prog_rdata[15:0];
			if (!(core_req && link.window_hit))
				core_extra_cycles <= psv_pkg::EXTRA_NONE;
			else if (core_in_repeat)
				core_extra_cycles <= core_rep_edge ? psv_pkg::EXTRA_TWO : psv_pkg::EXTRA_ONE;
			else
				core_extra_cycles <= core_move_op ? psv_pkg::EXTRA_ONE : psv_pkg::EXTRA_TWO;
		end
	end

	// Read decode.
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (s_axi_araddr)
			psv_pkg::ADDR_CORE_CONTROL: rd_word = {16'h0000, core_control_reg};
			psv_pkg::ADDR_VIEW_PAGE:    rd_word = {24'h00_0000, view_page_reg};
			psv_pkg::ADDR_TABLE_PAGE:   rd_word = {24'h00_0000, table_page_reg};
			psv_pkg::ADDR_PROG_HI:      rd_word = {24'h00_0000, prog_hi_reg};
			psv_pkg::ADDR_PROG_LO:      rd_word = {16'h0000, prog_lo_reg};
			psv_pkg::ADDR_EE_CMD:       rd_word = {29'h0000_0000, ee_op_reg};
			psv_pkg::ADDR_STATUS:       rd_word = {30'h0000_0000, tbl_busy_reg, ee_busy};
			default:                    rd_hit = 1'b0;
		endcase
	end

	// Read channel.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= psv_pkg::AXI_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_hit ? psv_pkg::AXI_OKAY : psv_pkg::AXI_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : program_space_data_window
`default_nettype wire

// >>> verification/prog_mem_model.sv
// Program memory model answering the window's fetch address.
`timescale 1ns/10ps
`default_nettype none
module prog_mem_model (
	// Fetch port.
	input  wire logic [23:0] prog_addr,
	output logic      [23:0] prog_rdata
);
	// Each word carries a pattern tied to the low 16 bits of its address, so a wrong offset or lane shows at once.
	assign prog_rdata = {prog_addr[7:0] ^ 8'h3C, prog_addr[15:0] ^ 16'hA55A};
endmodule : prog_mem_model
`default_nettype wire

// >>> verification/program_space_data_window_sva.sv
// Checker of the window bridge behaviour at its core-side ports.
`timescale 1ns/10ps
`default_nettype none
module program_space_data_window_sva (
	// Clock, reset and core requests.
	input wire logic        aclk, aresetn, core_req, core_move_op, core_in_repeat, core_rep_edge,
	input wire logic        tbl_req, tbl_high,
	input wire logic [15:0] core_addr,
	// Answers.
	input wire logic        core_redirect, tbl_ignored, ee_busy,
	input wire logic [1:0]  core_extra_cycles,
	input wire logic [23:0] prog_addr
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// The window stays shut for the table cycle and the one after.
	sequence shut_two;
		!core_redirect ##1 !core_redirect;
	endsequence
	// A command keeps the EEPROM busy for a long stretch, then frees it.
	sequence busy_span;
		ee_busy [*8] ##[1:12] !ee_busy;
	endsequence
	chk_table_shuts_view: assert property (tbl_req |=> shut_two)
		else $error("window used during a table operation");
	chk_low_half_direct: assert property (core_req && !core_addr[15] |=> !core_redirect)
		else $error("low data address redirected");
	chk_window_address: assert property (core_redirect |->
		!prog_addr[23] && prog_addr[14:0] == $past(core_addr[14:0])) else $error("window address wrong");
	chk_window_cost: assert property (core_redirect |-> core_extra_cycles != psv_pkg::EXTRA_NONE)
		else $error("window access without extra cycle");
	chk_plain_free: assert property (!core_redirect |-> core_extra_cycles == psv_pkg::EXTRA_NONE)
		else $error("plain access with extra cycles");
	chk_move_one: assert property (core_redirect && $past(core_move_op && !core_in_repeat) |->
		core_extra_cycles == psv_pkg::EXTRA_ONE) else $error("move cost wrong");
	chk_other_two: assert property (core_redirect && $past(!core_move_op && !core_in_repeat) |->
		core_extra_cycles == psv_pkg::EXTRA_TWO) else $error("other instruction cost wrong");
	chk_repeat_cost: assert property (core_redirect && $past(core_in_repeat) |->
		core_extra_cycles == ($past(core_rep_edge) ? psv_pkg::EXTRA_TWO : psv_pkg::EXTRA_ONE))
		else $error("repeat cost wrong");
	chk_high_ignored: assert property (tbl_ignored |-> $past(tbl_req && tbl_high))
		else $error("ignore flag without high table op");
	chk_busy_span: assert property ($rose(ee_busy) |-> busy_span)
		else $error("EEPROM busy span wrong");
endmodule : program_space_data_window_sva
`default_nettype wire

// >>> verification/program_space_data_window_bench.sv
// Bench of the window bridge: registers, window fetches, table capture and EEPROM commands.
`timescale 1ns/10ps
`default_nettype none
module program_space_data_window_bench;
	// Bus, core and memory signals.
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	logic        rready = 1'b0, creq = 1'b0, cmove = 1'b0, crep = 1'b0, cedge = 1'b0, treq = 1'b0;
	logic        twr = 1'b0, thi = 1'b0, awready, wready, bvalid, arready, rvalid, redir, tign, busy;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic [15:0] caddr = '0, taddr = '0, crd, eewd;
	logic [1:0]  bresp, rresp, extra;
	logic [23:0] paddr, prd;
	logic [7:0]  page = 8'hFF;
	int          miscompares = 0, samples_checked = 0, cyc = 0;
	// Free-running clock.
	always #25 aclk = ~aclk;
	// Device and program memory.
	program_space_data_window u_program_space_data_window (.aclk, .aresetn, .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.core_req(creq), .core_addr(caddr), .core_move_op(cmove), .core_in_repeat(crep),
		.core_rep_edge(cedge), .tbl_req(treq), .tbl_write(twr), .tbl_high(thi), .tbl_addr(taddr),
		.tbl_wdata(16'h5AA5), .prog_rdata(prd), .core_redirect(redir), .core_extra_cycles(extra),
		.core_rdata(crd), .prog_addr(paddr), .tbl_ignored(tign), .ee_busy(busy), .ee_wdata(eewd));
	prog_mem_model u_prog_mem_model (.prog_addr(paddr), .prog_rdata(prd));
	// Compares one result and counts it.
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	// Register write: address and data offered together, each released when taken.
	task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", er, bresp);
	endtask : wr
	// Register read with response and optional data comparison.
	task automatic rdx(input logic [31:0] a, e, input logic [1:0] er, input logic cd);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rresp", er, rresp);
		if (cd) chk("rdata", e, rdata);
	endtask : rdx
	// One core data access; vw says the window is enabled.
	task automatic acc(input logic [15:0] a, input logic mv, rp, ed, vw, input logic [1:0] ex);
		logic [23:0] pa;
		pa = (vw && a[15]) ? {1'b0, page, a[14:0]} : {8'h00, a[15:1], 1'b0};
		@(posedge aclk);
		creq <= 1'b1;
		caddr <= a;
		cmove <= mv;
		crep <= rp;
		cedge <= ed;
		@(posedge aclk);
		creq <= 1'b0;
		#1;
		chk("redirect", vw && a[15], redir);
		chk("extra", ex, extra);
		chk("prog_addr", pa, paddr);
		if (vw && a[15]) begin
			@(posedge aclk);
			#1;
			chk("core_rdata", a[0] ? {8'h00, pa[7:0] ^ 8'h3C} : pa[15:0] ^ 16'hA55A, crd);
		end
	endtask : acc
	// Cuts a hang short.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// Main sequence.
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdx(psv_pkg::ADDR_CORE_CONTROL, 32'(psv_pkg::CORE_RESET), psv_pkg::AXI_OKAY, 1'b1);
		rdx(psv_pkg::ADDR_VIEW_PAGE, 32'(psv_pkg::PAGE_RESET), psv_pkg::AXI_OKAY, 1'b1);
		wr(psv_pkg::ADDR_VIEW_PAGE, 32'h0000_00FF, psv_pkg::AXI_OKAY);
		wr(psv_pkg::ADDR_VIEW_PAGE, 32'h0000_0055, psv_pkg::AXI_OKAY);
		rdx(psv_pkg::ADDR_VIEW_PAGE, 32'h0000_00FF, psv_pkg::AXI_OKAY, 1'b1);
		rdx(32'h0000_0040, 32'h0, psv_pkg::AXI_SLVERR, 1'b0);
		wr(psv_pkg::ADDR_TABLE_PAGE, 32'h0000_00FF, psv_pkg::AXI_OKAY);
		wr(psv_pkg::ADDR_CORE_CONTROL, 32'h0000_0004, psv_pkg::AXI_OKAY);
		acc(16'h8124, 1'b1, 1'b0, 1'b0, 1'b1, 2'h1);
		acc(16'h8125, 1'b0, 1'b0, 1'b0, 1'b1, 2'h2);
		acc(16'hC124, 1'b0, 1'b1, 1'b1, 1'b1, 2'h2);
		acc(16'hC124, 1'b1, 1'b1, 1'b0, 1'b1, 2'h1);
		acc(16'h0124, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0);
		wr(psv_pkg::ADDR_VIEW_PAGE, 32'h0, psv_pkg::AXI_OKAY);
		page = 8'h00;
		acc(16'hFFFE, 1'b1, 1'b0, 1'b0, 1'b1, 2'h1);
		wr(psv_pkg::ADDR_CORE_CONTROL, 32'h0, psv_pkg::AXI_OKAY);
		acc(16'h8124, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
		wr(psv_pkg::ADDR_CORE_CONTROL, 32'h0000_0004, psv_pkg::AXI_OKAY);
		// Table write with a window access right behind it, then a high-word op on the EEPROM page.
		treq <= 1'b1;
		twr <= 1'b1;
		taddr <= 16'h1235;
		@(posedge aclk);
		treq <= 1'b0;
		creq <= 1'b1;
		#1;
		chk("table_addr", 24'hFF1235, paddr);
		chk("ee_wdata", 16'h5AA5, eewd);
		@(posedge aclk);
		creq <= 1'b0;
		treq <= 1'b1;
		twr <= 1'b0;
		thi <= 1'b1;
		#1;
		chk("redirect", 1'b0, redir);
		@(posedge aclk);
		treq <= 1'b0;
		#1;
		chk("tbl_ignored", 1'b1, tign);
		rdx(psv_pkg::ADDR_PROG_HI, 32'h0000_007F, psv_pkg::AXI_OKAY, 1'b1);
		rdx(psv_pkg::ADDR_PROG_LO, 32'h0000_1234, psv_pkg::AXI_OKAY, 1'b1);
		// Every EEPROM command, each waited out before the next is issued.
		for (int c = 1; c < 7; c++) begin
			wr(psv_pkg::ADDR_EE_CMD, 32'(c), psv_pkg::AXI_OKAY);
			#1;
			chk("ee_busy", 1'b1, busy);
			for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge aclk);
			#1;
			chk("ee_idle", 1'b0, busy);
		end
		rdx(psv_pkg::ADDR_STATUS, 32'h0000_0000, psv_pkg::AXI_OKAY, 1'b1);
		report_and_stop();
	end
endmodule : program_space_data_window_bench
bind program_space_data_window program_space_data_window_sva u_program_space_data_window_sva (.aclk, .aresetn,
	.core_req, .core_move_op, .core_in_repeat, .core_rep_edge, .tbl_req, .tbl_high, .core_addr, .core_redirect,
	.tbl_ignored, .ee_busy, .core_extra_cycles, .prog_addr);
`default_nettype wire
